// *** ccm_pkg.sv ***
// constants shared by the compare/capture module array
// assumes an 8-bit special-function register port and one system clock
package ccm_pkg;

   // ------------------------------------------------------------
   // array shape
   // ------------------------------------------------------------
   localparam int unsigned CCM_NCH = 8;
   localparam int unsigned CCM_NCAP = 6;
   localparam int unsigned CCM_NPAIR = 3;

   // ------------------------------------------------------------
   // register addresses and pages
   // ------------------------------------------------------------
   localparam logic [7:0] CCM_A_RELOAD = 8'hce;
   localparam logic [7:0] CCM_A_CTRL = 8'hd8;
   localparam logic [7:0] CCM_A_MODE = 8'hda;
   localparam logic [7:0] CCM_A_CNT_LO = 8'he9;
   localparam logic [7:0] CCM_A_CMP_LO = 8'hea;
   localparam logic [7:0] CCM_A_AUX = 8'hf2;
   localparam logic [7:0] CCM_A_CNT_HI = 8'hf9;
   localparam logic [7:0] CCM_A_CMP_HI = 8'hfa;
   localparam logic [3:0] CCM_PAGE_LO = 4'h0;
   localparam logic [3:0] CCM_PAGE_HI = 4'h1;
   localparam logic [7:0] CCM_REG_RST = 8'h00;

   // ------------------------------------------------------------
   // mode register fields
   // ------------------------------------------------------------
   localparam int unsigned CCM_M_DTE = 7;
   localparam int unsigned CCM_M_ECOM = 6;
   localparam int unsigned CCM_M_CAPP = 5;
   localparam int unsigned CCM_M_CAPN = 4;
   localparam int unsigned CCM_M_MAT = 3;
   localparam int unsigned CCM_M_TOG = 2;
   localparam int unsigned CCM_M_PWM = 1;
   localparam int unsigned CCM_M_IRQ = 0;
   localparam logic [7:0] CCM_MODE_MASK_NOCAP = 8'hdf;

   // ------------------------------------------------------------
   // pwm auxiliary register fields
   // ------------------------------------------------------------
   localparam int unsigned CCM_X_RES_HI = 7;
   localparam int unsigned CCM_X_RES_LO = 6;
   localparam int unsigned CCM_X_FLAG = 3;
   localparam int unsigned CCM_X_INV = 2;
   localparam int unsigned CCM_X_EXT_H = 1;
   localparam int unsigned CCM_X_EXT_L = 0;
   localparam logic [7:0] CCM_AUX_WMASK = 8'hc7;

   typedef enum logic [1:0] {
      CCM_RES8 = 2'b00,
      CCM_RES10 = 2'b01,
      CCM_RES12 = 2'b10,
      CCM_RES16 = 2'b11
   } ccm_res_e;

endpackage

// *** ccm_chan.sv ***
// one compare/capture/pwm module: pin sync, edge capture, compare, pwm
// assumes the counter and all sfr registers live in the parent
`timescale 1ns/100ps
module ccm_chan
#(
   parameter bit HAS_CAPTURE = 1'b1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // shared counter
   input wire logic [15:0] count,
   input wire logic cnt_step,
   // module settings
   input wire logic [7:0] mode,
   input wire logic [15:0] cmp,
   input wire logic ext_l,
   input wire logic [1:0] res,
   input wire logic inv,
   // pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // events to the parent
   output logic capture_p,
   output logic match_p
);
   import ccm_pkg::*;

   logic [2:0] sync_q;
   logic tog_q;
   logic pin_out_q;
   logic pin_oe_q;

   // ------------------------------------------------------------
   // capture edge detection
   // ------------------------------------------------------------
   // sync_q[0] feeds only sync_q[1]; edges are seen on [1] vs [2]
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         sync_q <= 3'h0;
      else if (clk_en)
         sync_q <= {sync_q[1:0], pin_in};
   end

   wire rise = sync_q[1] & ~sync_q[2];
   wire fall = ~sync_q[1] & sync_q[2];
   // either, both or no edge arms a capture
   assign capture_p = HAS_CAPTURE & clk_en & ((rise & mode[CCM_M_CAPP])
      | (fall & mode[CCM_M_CAPN]));

   // ------------------------------------------------------------
   // compare and pwm
   // ------------------------------------------------------------
   // match only on the cycle after a counter step, so one hit per value
   assign match_p = clk_en & cnt_step & mode[CCM_M_ECOM] & (count == cmp);

   // mask of the low counter bits in use for the chosen width
   logic [15:0] res_mask;
   always_comb
   begin
      case (res)
         CCM_RES10: res_mask = 16'h03ff;
         CCM_RES12: res_mask = 16'h0fff;
         CCM_RES16: res_mask = 16'hffff;
         default: res_mask = 16'h00ff;
      endcase
   end

   // 9-bit compare lets 0x100 give 0% and 0x000 give 100% high time
   wire low8 = {1'b0, count[7:0]} < {ext_l, cmp[7:0]};
   wire lown = (count & res_mask) < (cmp & res_mask);
   wire pwm_lvl = (res == CCM_RES8) ? ~low8 : ~lown;
   wire pwm_on = mode[CCM_M_ECOM] & mode[CCM_M_PWM];
   wire raw = pwm_on ? pwm_lvl : tog_q;

   // toggle state for the high speed output
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         tog_q <= 1'b0;
      else if (match_p & mode[CCM_M_TOG] & ~pwm_on)
         tog_q <= ~tog_q;
   end

   // registered pin drive; enable follows the output modes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pin_out_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_out_q <= raw ^ inv;
         pin_oe_q <= mode[CCM_M_ECOM] & (mode[CCM_M_PWM] | mode[CCM_M_TOG]);
      end
   end

   assign pin_out = pin_out_q;
   assign pin_oe = pin_oe_q;

endmodule

// *** ccm_top.sv ***
// compare/capture module array: shared counter, eight modules, sfr port
// assumes a single-cycle sfr write strobe and a same-clock counter tick
//
// Function
// - overflow reloads counter low byte from reload
// - each of eight modules has a mode register
// - dead-time honoured on 0,2,4 in buffer mode
// - comparator enable bit gates the compare logic
// - rise, fall or both edges trigger capture
// - modules 6 and 7 have no capture
// - match sets flag in control register, 0-5
// - match on 6,7 sets flag in auxiliary register
// - toggle bit inverts pin on each match
// - pwm bit drives pin as pwm output
// - interrupt request only with enable bit set
// - two bytes form 16-bit compare/capture value
// - 8-bit pwm duty spans 0% to 100%
// - module 6 bit 7 buffers pair 6/7 in 10/12/16-bit pwm
// - resolution field picks 8/10/12/16 bit period
// - hardware sets 6/7 flags, software clears
// - invert bit inverts pin output
// - auxiliary bits extend compare bytes to 9
// - low byte wrap reloads active duty value in 8-bit pwm
// - capture copies counter and sets flag
`timescale 1ns/100ps
module ccm_top
#(
   parameter int unsigned CAP_CHANS = ccm_pkg::CCM_NCAP
)
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // counter step pulse from the clock selector
   input wire logic count_tick,
   // special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [3:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // pair buffer enables for 0/1, 2/3, 4/5
   input wire logic [ccm_pkg::CCM_NPAIR-1:0] pair_buffer_enable,
   // module pins
   input wire logic [ccm_pkg::CCM_NCH-1:0] module_io_pin_in,
   output logic [ccm_pkg::CCM_NCH-1:0] module_io_pin_out,
   output logic [ccm_pkg::CCM_NCH-1:0] module_io_pin_oe,
   // requests and dead-time controls
   output logic [ccm_pkg::CCM_NCH-1:0] module_irq_req,
   output logic [ccm_pkg::CCM_NPAIR-1:0] dead_time_active
);
   import ccm_pkg::*;

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (CAP_CHANS > CCM_NCH)
   begin : g_bad_cap
      $error("capture channel count above module count");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] base_low_reload_q;
   logic [15:0] base_count_q;
   logic [15:0] base_count_d;
   logic step_q;
   logic [7:0] mode_q [CCM_NCH];
   logic [7:0] mode_d [CCM_NCH];
   logic [7:0] cmp_lo_q [CCM_NCH];
   logic [7:0] cmp_lo_d [CCM_NCH];
   logic [7:0] cmp_hi_q [CCM_NCH];
   logic [7:0] cmp_hi_d [CCM_NCH];
   logic [7:0] aux_q [CCM_NCH];
   logic [7:0] aux_d [CCM_NCH];
   logic [CCM_NCH-1:0] flag_q;
   logic [CCM_NCH-1:0] flag_d;
   logic [CCM_NCH-1:0] irq_q;
   logic [CCM_NPAIR-1:0] dte_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   // per-module decode and events
   logic [CCM_NCH-1:0] hit_mode;
   logic [CCM_NCH-1:0] hit_lo;
   logic [CCM_NCH-1:0] hit_hi;
   logic [CCM_NCH-1:0] hit_aux;
   logic [CCM_NCH-1:0] cap_p;
   logic [CCM_NCH-1:0] match_p;
   logic [CCM_NCH-1:0] reload8;
   logic [CCM_NCH-1:0] pin_out_w;
   logic [CCM_NCH-1:0] pin_oe_w;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // modules 0/1 sit on page 0, 6/7 take the same slots on page 1,
   // and 2..5 answer on every page
   function automatic logic hit_chan(input logic [7:0] a, input logic [7:0] base,
      input logic [3:0] pg, input int ch);
      logic [7:0] rel;
      logic res;
      rel = a - base;
      if (ch >= 6)
         res = (pg == CCM_PAGE_HI) && (rel == 8'(ch - 6));
      else if (ch < 2)
         res = (pg == CCM_PAGE_LO) && (rel == 8'(ch));
      else
         res = (rel == 8'(ch));
      return res;
   endfunction

   wire wr = sfr_wr & clk_en;
   wire wr_reload = wr & (sfr_addr == CCM_A_RELOAD);
   wire wr_ctrl = wr & (sfr_addr == CCM_A_CTRL);
   wire tick = clk_en & count_tick;
   wire low_wrap = tick & (base_count_q[7:0] == 8'hff);

   // ------------------------------------------------------------
   // base counter
   // ------------------------------------------------------------
   // on a full overflow the low byte restarts from the reload value,
   // which shortens the period for odd pwm resolutions
   assign base_count_d = (base_count_q == 16'hffff) ? {8'h00, base_low_reload_q}
      : base_count_q + 16'h0001;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         base_count_q <= 16'h0000;
         step_q <= 1'b0;
         base_low_reload_q <= CCM_REG_RST;
      end
      else if (clk_en)
      begin
         step_q <= count_tick;
         if (count_tick)
            base_count_q <= base_count_d;
         if (wr_reload)
            base_low_reload_q <= sfr_wdata;
      end
   end

   // ------------------------------------------------------------
   // per-module registers and channel logic
   // ------------------------------------------------------------
   for (genvar i = 0; i < CCM_NCH; i++)
   begin : g_mod
      localparam bit HAS_CAP = (i < CAP_CHANS);
      logic [1:0] res;
      logic per_wrap;
      logic buf_load;

      assign hit_mode[i] = hit_chan(sfr_addr, CCM_A_MODE, sfr_page, i);
      assign hit_lo[i] = hit_chan(sfr_addr, CCM_A_CMP_LO, sfr_page, i);
      assign hit_hi[i] = hit_chan(sfr_addr, CCM_A_CMP_HI, sfr_page, i);
      assign hit_aux[i] = hit_chan(sfr_addr, CCM_A_AUX, sfr_page, i);
      assign res = aux_q[i][CCM_X_RES_HI:CCM_X_RES_LO];

      // period end of this module's own resolution
      assign per_wrap = tick & ((base_count_q | ~16'h00ff) == 16'hffff
         && res == CCM_RES8
         || (base_count_q | ~16'h03ff) == 16'hffff && res == CCM_RES10
         || (base_count_q | ~16'h0fff) == 16'hffff && res == CCM_RES12
         || base_count_q == 16'hffff && res == CCM_RES16);

      // 8-bit pwm reloads the active duty from the high byte each wrap
      assign reload8[i] = low_wrap & mode_q[i][CCM_M_ECOM] & mode_q[i][CCM_M_PWM]
         & (res == CCM_RES8);

      // buffered wide pwm on pair 6/7: module 7 holds the next duty,
      // so both bytes change together at the period end
      if (i == 6)
      begin : g_buf
         assign buf_load = mode_q[6][CCM_M_DTE] & mode_q[6][CCM_M_PWM]
            & mode_q[6][CCM_M_ECOM] & per_wrap & (res != CCM_RES8);
      end
      else
      begin : g_nobuf
         assign buf_load = 1'b0;
      end

      // capture beats a reload, which beats a software write
      assign cmp_lo_d[i] = cap_p[i] ? base_count_q[7:0]
         : reload8[i] ? cmp_hi_q[i]
         : buf_load ? cmp_lo_q[(i + 1) % CCM_NCH]
         : (wr & hit_lo[i]) ? sfr_wdata : cmp_lo_q[i];
      assign cmp_hi_d[i] = cap_p[i] ? base_count_q[15:8]
         : buf_load ? cmp_hi_q[(i + 1) % CCM_NCH]
         : (wr & hit_hi[i]) ? sfr_wdata : cmp_hi_q[i];

      // capture bit 5 does not exist on the capture-less modules
      assign mode_d[i] = (wr & hit_mode[i])
         ? (HAS_CAP ? sfr_wdata : sfr_wdata & CCM_MODE_MASK_NOCAP)
         : mode_q[i];

      // bits 5:3 stored as zero: 5:4 reserved, the flag bit lives in flag_q
      assign aux_d[i] = {
         (wr & hit_aux[i]) ? sfr_wdata[7:6] : aux_q[i][7:6],
         3'h0,
         (wr & hit_aux[i]) ? sfr_wdata[CCM_X_INV:CCM_X_EXT_H]
            : aux_q[i][CCM_X_INV:CCM_X_EXT_H],
         reload8[i] ? aux_q[i][CCM_X_EXT_H]
            : (wr & hit_aux[i]) ? sfr_wdata[CCM_X_EXT_L] : aux_q[i][CCM_X_EXT_L]};

      // set wins over a software clear in the same cycle
      if (i < 6)
      begin : g_flag_ctrl
         assign flag_d[i] = (wr_ctrl ? sfr_wdata[i] : flag_q[i])
            | cap_p[i] | (match_p[i] & mode_q[i][CCM_M_MAT]);
      end
      else
      begin : g_flag_aux
         assign flag_d[i] = ((wr & hit_aux[i]) ? sfr_wdata[CCM_X_FLAG] : flag_q[i])
            | (match_p[i] & mode_q[i][CCM_M_MAT]);
      end

      always_ff @(posedge clk)
      begin
         if (sys_rst)
         begin
            mode_q[i] <= CCM_REG_RST;
            cmp_lo_q[i] <= CCM_REG_RST;
            cmp_hi_q[i] <= CCM_REG_RST;
            aux_q[i] <= CCM_REG_RST;
         end
         else if (clk_en)
         begin
            mode_q[i] <= mode_d[i];
            cmp_lo_q[i] <= cmp_lo_d[i];
            cmp_hi_q[i] <= cmp_hi_d[i];
            aux_q[i] <= aux_d[i];
         end
      end

      ccm_chan #(
         .HAS_CAPTURE(HAS_CAP)
      ) u_chan (
         .clk(clk),
         .sys_rst(sys_rst),
         .clk_en(clk_en),
         .count(base_count_q),
         .cnt_step(step_q),
         .mode(mode_q[i]),
         .cmp({cmp_hi_q[i], cmp_lo_q[i]}),
         .ext_l(aux_q[i][CCM_X_EXT_L]),
         .res(res),
         .inv(aux_q[i][CCM_X_INV]),
         .pin_in(module_io_pin_in[i]),
         .pin_out(pin_out_w[i]),
         .pin_oe(pin_oe_w[i]),
         .capture_p(cap_p[i]),
         .match_p(match_p[i])
      );
   end

   // ------------------------------------------------------------
   // flags, requests, dead-time
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flag_q <= '0;
         irq_q <= '0;
         dte_q <= '0;
      end
      else if (clk_en)
      begin
         flag_q <= flag_d;
         for (int k = 0; k < CCM_NCH; k++)
            irq_q[k] <= flag_q[k] & mode_q[k][CCM_M_IRQ];
         for (int k = 0; k < CCM_NPAIR; k++)
            dte_q[k] <= mode_q[2 * k][CCM_M_DTE] & pair_buffer_enable[k];
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   // unmapped addresses and reserved bits read as zero
   always_comb
   begin
      rdata_d = 8'h00;
      if (sfr_addr == CCM_A_RELOAD)
         rdata_d = base_low_reload_q;
      if (sfr_addr == CCM_A_CTRL)
         rdata_d = {2'b00, flag_q[5:0]};
      if (sfr_addr == CCM_A_CNT_LO)
         rdata_d = base_count_q[7:0];
      if (sfr_addr == CCM_A_CNT_HI)
         rdata_d = base_count_q[15:8];
      for (int k = 0; k < CCM_NCH; k++)
      begin
         if (hit_mode[k])
            rdata_d = mode_q[k];
         if (hit_lo[k])
            rdata_d = cmp_lo_q[k];
         if (hit_hi[k])
            rdata_d = cmp_hi_q[k];
         if (hit_aux[k])
            rdata_d = aux_q[k] | ((k >= 6 && flag_q[k]) ? 8'h08 : 8'h00);
      end
   end

   // read answer registered one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_q <= 8'h00;
      else if (clk_en & sfr_rd)
         rdata_q <= rdata_d;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign sfr_rdata = rdata_q;
   assign module_io_pin_out = pin_out_w;
   assign module_io_pin_oe = pin_oe_w;
   assign module_irq_req = irq_q;
   assign dead_time_active = dte_q;

endmodule

// *** ccm_pin_model.sv ***
// pin model for the far side of the module pins
// assumes an active-high drive enable from the design, one bit per pin
`timescale 1ns/100ps
module ccm_pin_model
(
   // design side
   input wire logic [7:0] drive_out,
   input wire logic [7:0] drive_oe,
   // outside source
   input wire logic [7:0] ext_level,
   input wire logic [7:0] ext_en,
   // resolved level
   output logic [7:0] pin_level
);
   // ------------------------------------------------------------
   // wire resolution
   // ------------------------------------------------------------
   // released pin follows ext_level when ext_en is set, else goes to the pull-up; never keeps its last value
   assign pin_level = (drive_oe & drive_out) | (~drive_oe & ext_en & ext_level)
                      | (~drive_oe & ~ext_en);
endmodule

// *** ccm_top_monitor.sv ***
// port-level checker for the module array
// assumes it is bound to ccm_top and sees only its ports
`timescale 1ns/100ps
module ccm_top_monitor
#(
   parameter int unsigned CAP_CHANS = 6
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic [3:0] sfr_page,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   // pins, requests, dead-time
   input wire logic [2:0] pair_buffer_enable,
   input wire logic [7:0] module_io_pin_out,
   input wire logic [7:0] module_io_pin_oe,
   input wire logic [7:0] module_irq_req,
   input wire logic [2:0] dead_time_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   AST_RESET_QUIET: assert property ($fell(sys_rst) |->
      module_irq_req == 8'h00 && module_io_pin_oe == 8'h00 && sfr_rdata == 8'h00)
      else $error("outputs not quiet after reset");
   AST_NOCAP_RSV: assert property (sfr_rd && clk_en && sfr_page == 4'h1 &&
      sfr_addr inside {8'hda, 8'hdb} |=> sfr_rdata[5] == 1'b0)
      else $error("capture bit of module 6 or 7 reads set");
   AST_AUX_RSV: assert property (sfr_rd && clk_en &&
      sfr_addr inside {[8'hf2:8'hf7]} |=> sfr_rdata[5:4] == 2'b00)
      else $error("reserved auxiliary bits read set");
   AST_AUX_FLAG_LOW: assert property (sfr_rd && clk_en && (sfr_addr inside {[8'hf4:8'hf7]}
      || (sfr_addr inside {8'hf2, 8'hf3} && sfr_page != 4'h1)) |=> !sfr_rdata[3])
      else $error("auxiliary flag set on modules 0 to 5");
   AST_CTRL_TOP: assert property (sfr_rd && clk_en && sfr_addr == 8'hd8
      |=> sfr_rdata[7:6] == 2'b00)
      else $error("control register top bits read set");
   AST_DT_NEEDS_BUF: assert property ((clk_en && pair_buffer_enable == 3'b000) [*2]
      |-> dead_time_active == 3'b000)
      else $error("dead-time active without buffer mode");
   AST_RDATA_HOLD: assert property (!(sfr_rd && clk_en) |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   AST_FREEZE: assert property (!clk_en |=> $stable(module_io_pin_out)
      && $stable(module_irq_req))
      else $error("state moved while clock enable low");

   // ------------------------------------------------------------
   // covers
   // ------------------------------------------------------------
   cover property ($rose(module_irq_req[0]));
   cover property ($rose(module_io_pin_out[2]));
   cover property (dead_time_active[0]);
endmodule

bind ccm_top ccm_top_monitor #(.CAP_CHANS(CAP_CHANS)) u_mon (.clk(clk), .sys_rst(sys_rst),
   .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .pair_buffer_enable(pair_buffer_enable),
   .module_io_pin_out(module_io_pin_out), .module_io_pin_oe(module_io_pin_oe),
   .module_irq_req(module_irq_req), .dead_time_active(dead_time_active));

// *** testbench.sv ***
// self-checking bench for the module array
// assumes ccm_top, its checker and the pin model are compiled first
`timescale 1ns/100ps
module testbench;
   import ccm_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk, sys_rst, clk_en, count_tick, sfr_wr, sfr_rd;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pin_in, pin_out, pin_oe, irq, ext_level, ext_en;
   logic [3:0] sfr_page;
   logic [2:0] pbe, dt;
   int n_mismatch = 0;
   int samples_checked = 0;

   ccm_top dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .count_tick(count_tick),
      .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pair_buffer_enable(pbe),
      .module_io_pin_in(pin_in), .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe),
      .module_irq_req(irq), .dead_time_active(dt));
   ccm_pin_model u_pins (.drive_out(pin_out), .drive_oe(pin_oe), .ext_level(ext_level),
      .ext_en(ext_en), .pin_level(pin_in));

   // ------------------------------------------------------------
   // bus, tick and compare helpers
   // ------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_page = p;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   // table entries are {address, page, data}
   task automatic wr_tab(input logic [19:0] t [], input int n);
      for (int i = 0; i < n; i++)
         wr(t[i][19:12], t[i][11:8], t[i][7:0]);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
      @(negedge clk);
      sfr_addr = a;
      sfr_page = p;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      chk_byte(sfr_rdata, e);
   endtask
   task automatic tick(input int n);
      @(negedge clk);
      count_tick = 1'b1;
      repeat (n) @(negedge clk);
      count_tick = 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rdc(CCM_A_RELOAD, CCM_PAGE_LO, CCM_REG_RST);
      rdc(CCM_A_MODE, CCM_PAGE_HI, CCM_REG_RST);
      rdc(CCM_A_CMP_HI, CCM_PAGE_LO, CCM_REG_RST);
      rdc(CCM_A_AUX, CCM_PAGE_LO, CCM_REG_RST);
      rdc(8'h00, CCM_PAGE_LO, 8'h00);
      wr(CCM_A_RELOAD, CCM_PAGE_LO, 8'h5a);
      rdc(CCM_A_RELOAD, CCM_PAGE_LO, 8'h5a);
      clk_en = 1'b0;
      wr(CCM_A_RELOAD, CCM_PAGE_LO, 8'h33);
      clk_en = 1'b1;
      rdc(CCM_A_RELOAD, CCM_PAGE_LO, 8'h5a);
   endtask
   task automatic t_compare;
      // 0,6,7 flag at 5 (7 without irq), 1 lacks comparator; 2,3 toggle at 8, 3 inverted
      logic [19:0] t [] = '{20'hea005, 20'heb005, 20'hea105, 20'heb105, 20'hec008,
         20'hed008, 20'hf5004, 20'hda049, 20'hdb009, 20'hda149, 20'hdb148, 20'hdc044,
         20'hdd044};
      wr_tab(t, 13);
      tick(10);
      idle(3);
      rdc(CCM_A_CTRL, CCM_PAGE_LO, 8'h01);
      rdc(CCM_A_AUX, CCM_PAGE_HI, 8'h08);
      rdc(CCM_A_AUX + 8'h01, CCM_PAGE_HI, 8'h08);
      chk_byte(irq, 8'h41);
      chk_byte(pin_out & 8'h0c, 8'h04);
      wr(CCM_A_AUX, CCM_PAGE_HI, 8'h00);
      wr(CCM_A_CTRL, CCM_PAGE_LO, 8'h00);
      idle(2);
      chk_byte(irq, 8'h00);
   endtask
   task automatic t_pwm;
      // module 4 duty 0x40, module 5 duty 0x100 (never high)
      logic [19:0] t [] = '{20'hfe040, 20'hff000, 20'hf7002, 20'hde042, 20'hdf042};
      wr_tab(t, 5);
      idle(3);
      chk_byte(pin_out & 8'h30, 8'h30);
      chk_byte(pin_oe, 8'h3c);
      tick(246);
      idle(3);
      chk_byte(pin_out & 8'h30, 8'h00);
      tick(64);
      idle(3);
      chk_byte(pin_out & 8'h30, 8'h10);
      // module 5 to 10-bit width: 0x0200 above the count, 0x0100 below it
      wr(CCM_A_AUX + 8'h05, CCM_PAGE_LO, 8'h40);
      wr(CCM_A_CMP_HI + 8'h05, CCM_PAGE_LO, 8'h02);
      idle(2);
      chk_byte(pin_out & 8'h20, 8'h00);
      wr(CCM_A_CMP_HI + 8'h05, CCM_PAGE_LO, 8'h01);
      idle(2);
      chk_byte(pin_out & 8'h20, 8'h20);
   endtask
   task automatic t_capture;
      // counter rests at 0x0140; 0 rise, 1 fall, 3 both edges
      logic [19:0] t [] = '{20'hda020, 20'hdb010, 20'hdd030, 20'hd8000};
      wr_tab(t, 4);
      ext_level = 8'h0b;
      idle(6);
      rdc(CCM_A_CMP_LO, CCM_PAGE_LO, 8'h40);
      rdc(CCM_A_CMP_HI, CCM_PAGE_LO, 8'h01);
      rdc(CCM_A_CTRL, CCM_PAGE_LO, 8'h09);
      wr(CCM_A_CTRL, CCM_PAGE_LO, 8'h00);
      ext_level = 8'h00;
      idle(6);
      rdc(CCM_A_CTRL, CCM_PAGE_LO, 8'h0a);
      rdc(CCM_A_CMP_LO + 8'h01, CCM_PAGE_LO, 8'h40);
   endtask
   task automatic t_modes;
      wr(CCM_A_MODE, CCM_PAGE_LO, 8'ha0);
      pbe = 3'b001;
      idle(3);
      chk_byte({5'h00, dt}, 8'h01);
      pbe = 3'b000;
      idle(3);
      chk_byte({5'h00, dt}, 8'h00);
      wr(CCM_A_MODE, CCM_PAGE_HI, 8'h20);
      rdc(CCM_A_MODE, CCM_PAGE_HI, 8'h00);
   endtask
   task automatic t_reload;
      // from 0x0140, 0xfec0 steps reach the wrap and reload
      wr(CCM_A_RELOAD, CCM_PAGE_LO, 8'hf0);
      tick(65216);
      idle(2);
      rdc(CCM_A_CNT_LO, CCM_PAGE_LO, 8'hf0);
      rdc(CCM_A_CNT_HI, CCM_PAGE_LO, 8'h00);
   endtask

   // ------------------------------------------------------------
   // verdict, clock, watchdog, main sequence
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // run needs about 65700 cycles
   initial
   begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      count_tick = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_page = 4'h0;
      pbe = 3'b000;
      ext_level = 8'h00;
      ext_en = 8'hff;
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      t_regs();
      t_compare();
      t_pwm();
      t_capture();
      t_modes();
      t_reload();
      complete_run();
   end
endmodule
